// *** shared/dmct_pkg.sv ***
// Purpose: shared constants and types of the dual mode compare timer
// Assumes: 10 MHz system clock, 8-bit cpu byte port with 3 address bits
// Notes: one cycle of the cpu port per access; no wait states
package dmct_pkg;

   // byte port address map
   localparam logic [2:0] ADDR_CNT_HI = 3'h0;
   localparam logic [2:0] ADDR_CNT_LO = 3'h1;
   localparam logic [2:0] ADDR_CMP_HI = 3'h2;
   localparam logic [2:0] ADDR_CMP_LO = 3'h3;
   localparam logic [2:0] ADDR_CTRL = 3'h4;
   localparam logic [2:0] ADDR_STAT = 3'h5;
   localparam logic [2:0] ADDR_IRQ_REQ = 3'h6;
   localparam logic [2:0] ADDR_IRQ_EN = 3'h7;

   // timer_control_reg fields
   localparam int CTL_HI_LEVEL = 7;
   localparam int CTL_WIDTH = 6;
   localparam int CTL_HSEL_HI = 5;
   localparam int CTL_HSEL_LO = 4;
   localparam int CTL_LO_LEVEL = 3;
   localparam int CTL_LSEL_TOP = 2;
   localparam int CTL_LSEL_HI = 1;
   localparam int CTL_LSEL_LO = 0;

   // timer_control_status fields
   localparam int ST_HI_OVF = 7;
   localparam int ST_HI_MATCH = 6;
   localparam int ST_HI_OVF_IE = 5;
   localparam int ST_HI_CLR = 4;
   localparam int ST_LO_OVF = 3;
   localparam int ST_LO_MATCH = 2;
   localparam int ST_LO_OVF_IE = 1;
   localparam int ST_LO_CLR = 0;
   localparam logic [7:0] ST_FLAG_MASK = 8'hCC;

   // interrupt request and enable register fields
   localparam int IRQ_HI = 1;
   localparam int IRQ_LO = 0;

   // reset values
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] CMP_RST = 8'hFF;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hFF;

   // prescaler taps
   localparam logic [4:0] PRE_DIV32_LAST = 5'h1F;
   localparam logic [3:0] PRE_DIV16_LAST = 4'hF;
   localparam logic [1:0] PRE_DIV4_LAST = 2'h3;

   // sub-clock source: one tick per 1/8192 s
   localparam int CLK_PERIOD_NS = 100;
   localparam int SUB_TICK_NS = 122070;
   localparam int SUB_TICK_CYC = SUB_TICK_NS / CLK_PERIOD_NS;
   localparam logic [10:0] SUB_LAST = 11'(SUB_TICK_CYC - 1);

   typedef enum logic [1:0]
   {
      SEL_DIV32,
      SEL_DIV16,
      SEL_DIV4,
      SEL_SUB
   } dmct_clksel_type;

endpackage

// *** design/dmct_chan.sv ***
// Purpose: one 8-bit counter byte with its compare byte
// Assumes: load, clear and increment come from the timer core
// Notes: a cpu load wins over clear, clear wins over increment
`timescale 1ns/10ps
module dmct_chan
   import dmct_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // counter controls
   input wire logic cnt_inc,
   input wire logic cnt_clr,
   input wire logic cnt_ld,
   input wire logic [7:0] cnt_ld_val,
   // compare controls
   input wire logic cmp_ld,
   input wire logic [7:0] cmp_ld_val,
   // state
   output logic [7:0] cnt_r,
   output logic [7:0] cmp_r
);

   // (RQ4) counter from zero
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cnt_r <= CNT_RST;
      end
      else if (cnt_ld)
      begin
         cnt_r <= cnt_ld_val;
      end
      else if (cnt_clr)
      begin
         cnt_r <= CNT_RST;
      end
      else if (cnt_inc)
      begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // (RQ5) compare from all ones
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cmp_r <= CMP_RST;
      end
      else if (cmp_ld)
      begin
         cmp_r <= cmp_ld_val;
      end
   end

   // (RQ16) cpu load takes effect
   a_load_wins: assert property (@(posedge clock) disable iff (reset) // RQ16
      cnt_ld |=> cnt_r == $past(cnt_ld_val))
      else $error("counter byte did not take cpu load");

   // (RQ17) compare load takes effect
   a_cmp_load: assert property (@(posedge clock) disable iff (reset) // RQ17
      cmp_ld |=> cmp_r == $past(cmp_ld_val))
      else $error("compare byte did not take cpu load");

endmodule

// *** design/dmct_timer.sv ***
// Purpose: 16-bit or dual 8-bit up-counter with output compare
// Assumes: cpu strobes last one cycle; read data valid one cycle later
// Notes: the slow source is derived from the system clock
//
// What this block does
// (RQ1) width bit 0: cascade bytes, high upper
// (RQ2) 16-bit mode counts on low clock select
// (RQ3) width bit 1: two counters, own selects
// (RQ4) reset loads counter bytes with zero
// (RQ5) reset loads compare bytes with ones
// (RQ6) 16-bit wrap sets high overflow flag
// (RQ7) overflow with enable sets irq request
// (RQ8) 8-bit wrap sets channel overflow flag
// (RQ9) 16-bit match sets match and request
// (RQ10) 8-bit match per channel, own flags
// (RQ11) high clear bit resets counter on match
// (RQ12) low clear bit resets low counter
// (RQ13) 16-bit match toggles high pin, presettable
// (RQ14) 8-bit match toggles channel pin, presettable
// (RQ15) flags clear by zero after read one
// (RQ16) cpu reads writes counter via staging
// (RQ17) cpu reads writes compare via staging; compare reads bypass the staging latch
// (RQ18) control picks width, clocks, pin levels
// (RQ19) cpu accesses upper byte first in 16-bit
// (RQ20) upper write stages, lower write commits
// (RQ21) upper counter read stages lower byte
// (RQ22) match fires as counter leaves value
// (RQ23) low channel idle in 16-bit mode
// (RQ24) hardware set beats software clear
`timescale 1ns/10ps
module dmct_timer
   import dmct_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // cpu byte port
   input wire logic [2:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // toggle output pins
   output logic high_toggle_pin,
   output logic low_toggle_pin,
   // interrupt lines to the cpu
   output logic irq_high,
   output logic irq_low
);

   logic [7:0] ctrl_r;
   logic [7:0] stat_r;
   logic [7:0] seen_r;
   logic [1:0] irq_req_r;
   logic [1:0] irq_en_r;
   logic [7:0] temp_r;
   logic [7:0] rdata_r;
   logic [4:0] pre_r;
   logic [10:0] sub_r;
   logic sub_tick_r;
   logic high_pin_r;
   logic low_pin_r;
   logic [7:0] cnt_h;
   logic [7:0] cnt_l;
   logic [7:0] cmp_h;
   logic [7:0] cmp_l;
   logic mode8;
   logic tick_h;
   logic tick_l;
   logic eq_h;
   logic eq_l;
   logic match_h;
   logic match_l;
   logic clr_h;
   logic clr_l;
   logic inc_h;
   logic inc_l;
   logic ovf_h;
   logic ovf_l;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_req;
   logic wr_en;
   logic cnt_h_ld;
   logic cnt_l_ld;
   logic [7:0] cnt_h_val;
   logic cmp_h_ld;
   logic cmp_l_ld;
   logic [7:0] cmp_h_val;
   logic [7:0] rd_val;
   logic [7:0] flag_set;

   // chosen source strobes for one counter clock
   function automatic logic sel_tick(input dmct_clksel_type sel,
                                     input logic [4:0] pre,
                                     input logic sub);
      logic t;
      t = 1'b0;
      case (sel)
         SEL_DIV32: t = (pre == PRE_DIV32_LAST);
         SEL_DIV16: t = (pre[3:0] == PRE_DIV16_LAST);
         SEL_DIV4: t = (pre[1:0] == PRE_DIV4_LAST);
         default: t = sub;
      endcase
      return t;
   endfunction

   // free running prescaler
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pre_r <= 5'h00;
      end
      else
      begin
         pre_r <= pre_r + 5'h01;
      end
   end

   // slow source divider
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         sub_r <= 11'h000;
         sub_tick_r <= 1'b0;
      end
      else
      begin
         sub_tick_r <= (sub_r == SUB_LAST);
         if (sub_r == SUB_LAST)
         begin
            sub_r <= 11'h000;
         end
         else
         begin
            sub_r <= sub_r + 11'h001;
         end
      end
   end

   assign mode8 = ctrl_r[CTL_WIDTH];

   // (RQ2) low select drives the cascade
   assign tick_l = sel_tick(dmct_clksel_type'(ctrl_r[CTL_LSEL_HI:CTL_LSEL_LO]),
                            pre_r, sub_tick_r);
   // (RQ3) high byte has its own select in 8-bit mode, low select in 16-bit
   assign tick_h = mode8 ?
      sel_tick(dmct_clksel_type'(ctrl_r[CTL_HSEL_HI:CTL_HSEL_LO]),
               pre_r, sub_tick_r) : tick_l;

   assign eq_h = (cnt_h == cmp_h);
   assign eq_l = (cnt_l == cmp_l);

   // (RQ22) match fires on the tick leaving the value
   // (RQ9) 16-bit compare uses both bytes
   assign match_h = mode8 ? (tick_h & eq_h) : (tick_l & eq_h & eq_l);
   // (RQ10) low channel compares its own bytes
   // (RQ23) low match idle in 16-bit mode
   assign match_l = mode8 & tick_l & eq_l;

   // (RQ11) high clear covers whole counter in 16-bit
   assign clr_h = match_h & stat_r[ST_HI_CLR];
   // (RQ12) low clear only from low channel in 8-bit
   assign clr_l = mode8 ? (match_l & stat_r[ST_LO_CLR]) : clr_h;

   // (RQ1) high byte counts on the low carry
   assign inc_l = tick_l & ~clr_l;
   assign inc_h = mode8 ? (tick_h & ~clr_h)
                        : (tick_l & (cnt_l == BYTE_MAX) & ~clr_h);

   // (RQ6) wrap of full width sets high overflow
   // (RQ8) wrap of each byte in 8-bit mode
   assign ovf_h = inc_h & (cnt_h == BYTE_MAX) &
                  (mode8 | (cnt_l == BYTE_MAX));
   assign ovf_l = mode8 & inc_l & (cnt_l == BYTE_MAX);

   // register write decode
   always_comb
   begin
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      wr_req = 1'b0;
      wr_en = 1'b0;
      cnt_h_ld = 1'b0;
      cnt_l_ld = 1'b0;
      cmp_h_ld = 1'b0;
      cmp_l_ld = 1'b0;
      cnt_h_val = bus_wdata;
      cmp_h_val = bus_wdata;
      if (!bus_wr)
      begin
         wr_ctrl = 1'b0;
      end
      // (RQ20) upper byte only stages in 16-bit mode
      else if (bus_addr == ADDR_CNT_HI)
      begin
         cnt_h_ld = mode8;
      end
      else if (bus_addr == ADDR_CNT_LO)
      begin
         cnt_l_ld = 1'b1;
         cnt_h_ld = ~mode8;
         cnt_h_val = mode8 ? bus_wdata : temp_r;
      end
      else if (bus_addr == ADDR_CMP_HI)
      begin
         cmp_h_ld = mode8;
      end
      else if (bus_addr == ADDR_CMP_LO)
      begin
         cmp_l_ld = 1'b1;
         cmp_h_ld = ~mode8;
         cmp_h_val = mode8 ? bus_wdata : temp_r;
      end
      else if (bus_addr == ADDR_CTRL)
      begin
         wr_ctrl = 1'b1;
      end
      else if (bus_addr == ADDR_STAT)
      begin
         wr_stat = 1'b1;
      end
      else if (bus_addr == ADDR_IRQ_REQ)
      begin
         wr_req = 1'b1;
      end
      else
      begin
         wr_en = 1'b1;
      end
   end

   dmct_chan u_chan_high
   (
      .clock(clock),
      .reset(reset),
      .cnt_inc(inc_h),
      .cnt_clr(clr_h),
      .cnt_ld(cnt_h_ld),
      .cnt_ld_val(cnt_h_val),
      .cmp_ld(cmp_h_ld),
      .cmp_ld_val(cmp_h_val),
      .cnt_r(cnt_h),
      .cmp_r(cmp_h)
   );

   dmct_chan u_chan_low
   (
      .clock(clock),
      .reset(reset),
      .cnt_inc(inc_l),
      .cnt_clr(clr_l),
      .cnt_ld(cnt_l_ld),
      .cnt_ld_val(bus_wdata),
      .cmp_ld(cmp_l_ld),
      .cmp_ld_val(bus_wdata),
      .cnt_r(cnt_l),
      .cmp_r(cmp_l)
   );

   // (RQ20) staging latch takes upper write data
   // (RQ21) upper counter read captures lower byte
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         temp_r <= CNT_RST;
      end
      else if (bus_wr && !mode8 &&
               (bus_addr == ADDR_CNT_HI || bus_addr == ADDR_CMP_HI))
      begin
         temp_r <= bus_wdata;
      end
      else if (bus_rd && !mode8 && bus_addr == ADDR_CNT_HI)
      begin
         temp_r <= cnt_l;
      end
   end

   // (RQ18) control register
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         ctrl_r <= CTRL_RST;
      end
      else if (wr_ctrl)
      begin
         ctrl_r <= bus_wdata;
      end
   end

   assign flag_set = {ovf_h, match_h, 2'b00, ovf_l, match_l, 2'b00};

   // status flags and enables
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         stat_r <= STAT_RST;
         seen_r <= STAT_RST;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (!ST_FLAG_MASK[i])
            begin
               if (wr_stat)
               begin
                  stat_r[i] <= bus_wdata[i];
               end
            end
            // (RQ24) set beats clear
            else if (flag_set[i])
            begin
               stat_r[i] <= 1'b1;
            end
            // (RQ15) clear by zero only after read as one
            else if (wr_stat && !bus_wdata[i] && seen_r[i])
            begin
               stat_r[i] <= 1'b0;
               seen_r[i] <= 1'b0;
            end
            else if (bus_rd && bus_addr == ADDR_STAT && stat_r[i])
            begin
               seen_r[i] <= 1'b1;
            end
         end
      end
   end

   // (RQ7) request flags; cpu writes zero to clear
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         irq_req_r <= 2'h0;
      end
      else
      begin
         // (RQ24) set beats clear
         if (match_h || (ovf_h && stat_r[ST_HI_OVF_IE]))
         begin
            irq_req_r[IRQ_HI] <= 1'b1;
         end
         else if (wr_req && !bus_wdata[IRQ_HI])
         begin
            irq_req_r[IRQ_HI] <= 1'b0;
         end
         if (match_l || (ovf_l && stat_r[ST_LO_OVF_IE]))
         begin
            irq_req_r[IRQ_LO] <= 1'b1;
         end
         else if (wr_req && !bus_wdata[IRQ_LO])
         begin
            irq_req_r[IRQ_LO] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         irq_en_r <= 2'h0;
      end
      else if (wr_en)
      begin
         irq_en_r <= bus_wdata[1:0];
      end
   end

   // (RQ7) cpu sees a request only when enabled
   assign irq_high = irq_req_r[IRQ_HI] & irq_en_r[IRQ_HI];
   assign irq_low = irq_req_r[IRQ_LO] & irq_en_r[IRQ_LO];

   // (RQ13) high pin preset by control, toggled on match
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         high_pin_r <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         high_pin_r <= bus_wdata[CTL_HI_LEVEL] ^ match_h;
      end
      else if (match_h)
      begin
         high_pin_r <= ~high_pin_r;
      end
   end

   // (RQ14) low pin preset by control, toggled on match
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         low_pin_r <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         low_pin_r <= bus_wdata[CTL_LO_LEVEL] ^ match_l;
      end
      else if (match_l)
      begin
         low_pin_r <= ~low_pin_r;
      end
   end

   assign high_toggle_pin = high_pin_r;
   assign low_toggle_pin = low_pin_r;

   // register read mux
   always_comb
   begin
      rd_val = 8'h00;
      if (bus_addr == ADDR_CNT_HI)
      begin
         rd_val = cnt_h;
      end
      // (RQ21) lower counter read returns staged byte
      else if (bus_addr == ADDR_CNT_LO)
      begin
         rd_val = mode8 ? cnt_l : temp_r;
      end
      else if (bus_addr == ADDR_CMP_HI)
      begin
         rd_val = cmp_h;
      end
      else if (bus_addr == ADDR_CMP_LO)
      begin
         rd_val = cmp_l;
      end
      else if (bus_addr == ADDR_CTRL)
      begin
         rd_val = ctrl_r;
      end
      else if (bus_addr == ADDR_STAT)
      begin
         rd_val = stat_r;
      end
      else if (bus_addr == ADDR_IRQ_REQ)
      begin
         rd_val = {6'h00, irq_req_r};
      end
      else
      begin
         rd_val = {6'h00, irq_en_r};
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rdata_r <= 8'h00;
      end
      else if (bus_rd)
      begin
         rdata_r <= rd_val;
      end
   end

   assign bus_rdata = rdata_r;

   a_match_flag: assert property (@(posedge clock) disable iff (reset) // RQ9
      match_h |=> stat_r[ST_HI_MATCH] && irq_req_r[IRQ_HI])
      else $error("high match did not set flag and request");

   a_ovf_flag: assert property (@(posedge clock) disable iff (reset) // RQ6
      ovf_h |=> stat_r[ST_HI_OVF] && cnt_h == 8'h00)
      else $error("high overflow flag not set on wrap");

   a_ovf_request: assert property (@(posedge clock) disable iff (reset) // RQ7
      ovf_l && stat_r[ST_LO_OVF_IE] |=> irq_req_r[IRQ_LO])
      else $error("low overflow did not raise request");

   a_clear_match: assert property (@(posedge clock) disable iff (reset) // RQ11
      clr_h && !bus_wr |=> cnt_h == 8'h00 && (mode8 || cnt_l == 8'h00))
      else $error("clear on match did not zero counter");

   a_low_idle: assert property (@(posedge clock) disable iff (reset) // RQ23
      !mode8 && !wr_ctrl |=> low_toggle_pin == $past(low_toggle_pin) &&
      !$rose(stat_r[ST_LO_MATCH]) && !$rose(stat_r[ST_LO_OVF]))
      else $error("low channel active in 16-bit mode");

   a_pin_toggle: assert property (@(posedge clock) disable iff (reset) // RQ13
      match_h && !wr_ctrl |=> high_toggle_pin != $past(high_toggle_pin))
      else $error("high pin did not toggle on match");

   a_flag_hold: assert property (@(posedge clock) disable iff (reset) // RQ15
      stat_r[ST_LO_MATCH] && !seen_r[ST_LO_MATCH] |=> stat_r[ST_LO_MATCH])
      else $error("match flag cleared without prior read");

   a_stage_commit: assert property (@(posedge clock) disable iff (reset) // RQ20
      bus_wr && !mode8 && bus_addr == ADDR_CNT_LO |=>
      cnt_h == $past(temp_r) && cnt_l == $past(bus_wdata))
      else $error("staged counter write did not commit both bytes");

   a_carry_cascade: assert property (@(posedge clock) disable iff (reset) // RQ1
      !mode8 && tick_l && cnt_l == BYTE_MAX && !clr_h && !bus_wr
      |=> cnt_h == $past(cnt_h) + 8'h01)
      else $error("high byte missed carry from low byte");

endmodule

// *** verif/dmct_cpu_model.sv ***
// Purpose: cpu side of the byte port of the dual mode compare timer
// Assumes: one strobe per access, raised 1 ns after the rising edge
// Notes: idle address and data are scrambled so stale values never help
`timescale 1ns/10ps
module dmct_cpu_model
   import dmct_pkg::*;
(
   // clock
   input wire logic clock,
   // byte port
   output logic [2:0] bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata
);
   initial
   begin
      bus_addr = 3'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(posedge clock);
      #1;
      bus_wr = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      bus_addr = a;
      bus_rd = 1'b1;
      @(posedge clock);
      #1;
      d = bus_rdata;
      bus_rd = 1'b0;
      bus_addr = ~a;
   endtask

   task automatic rd16(input logic [2:0] a_hi, output logic [15:0] v);
      rd(a_hi, v[15:8]);
      rd(a_hi + 3'h1, v[7:0]);
   endtask

   task automatic clr_status(input logic [7:0] keep);
      logic [7:0] s;
      rd(ADDR_STAT, s);
      wr(ADDR_STAT, keep & ~ST_FLAG_MASK);
   endtask
endmodule

// *** verif/dmct_timer_tb.sv ***
// Purpose: self-checking bench of the dual mode compare timer
// Assumes: 10 MHz clock, byte port driven by the cpu model
// Notes: an integer register model supplies the reset, compare and control readbacks
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
   begin \
      cmp_count++; \
      if ((got) !== (ex)) \
      begin \
         error_cnt++; \
         $display("unexpected %s: expected %h seen %h", nm, ex, got); \
      end \
   end
module dmct_timer_tb
   import dmct_pkg::*;
;
   logic clock;
   logic reset;
   logic [2:0] bus_addr;
   logic bus_wr;
   logic bus_rd;
   logic [7:0] bus_wdata;
   logic [7:0] bus_rdata;
   logic high_toggle_pin;
   logic low_toggle_pin;
   logic irq_high;
   logic irq_low;
   int error_cnt;
   int cmp_count;
   int m_reg [8];
   int m_stage;

   dmct_timer u_dmct_timer (
      .clock(clock), .reset(reset), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .high_toggle_pin(high_toggle_pin), .low_toggle_pin(low_toggle_pin),
      .irq_high(irq_high), .irq_low(irq_low));

   dmct_cpu_model u_dmct_cpu_model (
      .clock(clock), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // byte write that also updates the register model
   task automatic put(input logic [2:0] a, input logic [7:0] d);
      bit w16;
      w16 = (a < 3'h4) && (m_reg[ADDR_CTRL][CTL_WIDTH] == 1'b0);
      u_dmct_cpu_model.wr(a, d);
      if (w16 && !a[0])
         m_stage = d;
      else if (w16)
      begin
         m_reg[a - 3'h1] = m_stage;
         m_reg[a] = d;
      end
      else
         m_reg[a] = d;
   endtask

   // cycles until the chosen pin changes, bounded
   task automatic wait_flip(input bit hi_sel, input int lim, output int n);
      logic p0;
      p0 = hi_sel ? high_toggle_pin : low_toggle_pin;
      n = 0;
      while ((hi_sel ? high_toggle_pin : low_toggle_pin) === p0)
      begin
         @(posedge clock);
         #2;
         n++;
         if (n > lim)
         begin
            error_cnt++;
            $display("unexpected pin wait: expected toggle seen none");
            give_verdict();
         end
      end
   endtask

   initial
   begin
      logic [7:0] d;
      logic [15:0] v;
      logic [15:0] w;
      int n;
      int i;
      int ov;
      error_cnt = 0;
      cmp_count = 0;
      reset = 1'b1;
      m_reg = '{CNT_RST, CNT_RST, CMP_RST, CMP_RST, CTRL_RST, STAT_RST, 0, 0};
      m_stage = 0;
      repeat (3) @(posedge clock);
      #1;
      reset = 1'b0;
      i = $urandom(32'h0D582048);
      for (i = 0; i < 8; i++)
      begin
         u_dmct_cpu_model.rd(3'(i), d);
         `CHK("reset value", 8'(m_reg[i]), d)
      end
      w = 16'($urandom);
      put(ADDR_CMP_HI, w[15:8]);
      u_dmct_cpu_model.rd(ADDR_CMP_HI, d);
      `CHK("staged compare", 8'(m_reg[ADDR_CMP_HI]), d)
      put(ADDR_CMP_LO, w[7:0]);
      u_dmct_cpu_model.rd16(ADDR_CMP_HI, v);
      `CHK("compare", 16'({m_reg[2][7:0], m_reg[3][7:0]}), v)
      put(ADDR_CTRL, 8'h03);
      u_dmct_cpu_model.rd(ADDR_CTRL, d);
      `CHK("control", 8'(m_reg[ADDR_CTRL]), d)
      w = 16'($urandom);
      put(ADDR_CNT_HI, w[15:8]);
      put(ADDR_CNT_LO, w[7:0]);
      u_dmct_cpu_model.rd16(ADDR_CNT_HI, v);
      `CHK("counter", 1'b1, (v - w) <= 16'h0001)
      put(ADDR_CMP_HI, 8'h00);
      put(ADDR_CMP_LO, 8'h03);
      put(ADDR_STAT, 8'h10);
      put(ADDR_IRQ_EN, 8'h02);
      put(ADDR_CNT_HI, 8'h00);
      put(ADDR_CNT_LO, 8'h00);
      put(ADDR_CTRL, 8'h02);
      wait_flip(1'b1, 400, n);
      wait_flip(1'b1, 400, n);
      `CHK("high period", 16, n)
      `CHK("high irq", 1'b1, irq_high)
      `CHK("low pin", 1'b0, low_toggle_pin)
      put(ADDR_CTRL, 8'h03);
      put(ADDR_STAT, 8'h10);
      u_dmct_cpu_model.rd(ADDR_STAT, d);
      `CHK("flag kept", 8'h50, d)
      put(ADDR_STAT, 8'h10);
      u_dmct_cpu_model.rd(ADDR_STAT, d);
      `CHK("flag cleared", 8'h10, d)
      put(ADDR_IRQ_REQ, 8'h00);
      `CHK("irq cleared", 1'b0, irq_high)
      put(ADDR_CTRL, 8'h83);
      `CHK("pin preset", 1'b1, high_toggle_pin)
      // 16-bit overflow with and without enable
      put(ADDR_CMP_HI, 8'h80);
      put(ADDR_CMP_LO, 8'h00);
      put(ADDR_CTRL, 8'h02);
      for (ov = 0; ov < 2; ov++)
      begin
         u_dmct_cpu_model.clr_status(8'(ov << ST_HI_OVF_IE));
         put(ADDR_IRQ_REQ, 8'h00);
         put(ADDR_CNT_HI, 8'hFF);
         put(ADDR_CNT_LO, 8'hFC);
         repeat (40) @(posedge clock);
         u_dmct_cpu_model.rd(ADDR_STAT, d);
         `CHK("overflow status", 8'(8'h80 | (ov << ST_HI_OVF_IE)), d)
         u_dmct_cpu_model.rd(ADDR_IRQ_REQ, d);
         `CHK("overflow request", 8'(ov << IRQ_HI), d)
      end
      put(ADDR_CTRL, 8'h61);
      put(ADDR_CMP_LO, 8'h05);
      put(ADDR_CMP_HI, 8'h03);
      u_dmct_cpu_model.rd(ADDR_CMP_LO, d);
      `CHK("direct compare", 8'(m_reg[ADDR_CMP_LO]), d)
      u_dmct_cpu_model.clr_status(8'h11);
      put(ADDR_CNT_LO, 8'h00);
      put(ADDR_CNT_HI, 8'h00);
      wait_flip(1'b1, 400, n);
      wait_flip(1'b1, 400, n);
      `CHK("8-bit high period", 16, n)
      wait_flip(1'b0, 400, n);
      wait_flip(1'b0, 400, n);
      `CHK("8-bit low period", 96, n)
      `CHK("low irq masked", 1'b0, irq_low)
      put(ADDR_IRQ_EN, 8'h03);
      `CHK("low irq", 1'b1, irq_low)
      u_dmct_cpu_model.clr_status(8'h01);
      put(ADDR_CNT_HI, 8'hFE);
      repeat (16) @(posedge clock);
      u_dmct_cpu_model.rd(ADDR_STAT, d);
      `CHK("8-bit overflow", 8'h80, d & 8'h88)
      // low wrap with its overflow enable set
      put(ADDR_CNT_LO, 8'hFE);
      u_dmct_cpu_model.clr_status(8'h03);
      put(ADDR_IRQ_REQ, 8'h00);
      repeat (40) @(posedge clock);
      u_dmct_cpu_model.rd(ADDR_STAT, d);
      `CHK("8-bit low overflow", 8'h08, d & 8'h08)
      u_dmct_cpu_model.rd(ADDR_IRQ_REQ, d);
      `CHK("low overflow request", 8'h01, d & 8'h01)
      // slowest divider on low, slow source on high
      u_dmct_cpu_model.clr_status(8'h11);
      put(ADDR_CMP_HI, 8'h00);
      put(ADDR_CMP_LO, 8'h00);
      put(ADDR_CNT_HI, 8'h00);
      put(ADDR_CNT_LO, 8'h00);
      put(ADDR_CTRL, 8'h70);
      wait_flip(1'b0, 400, n);
      wait_flip(1'b0, 400, n);
      `CHK("div32 period", 32, n)
      wait_flip(1'b1, 2600, n);
      wait_flip(1'b1, 2600, n);
      `CHK("slow period", SUB_TICK_CYC, n)
      give_verdict();
   end
endmodule
